/* File: src/typec_attach_pkg.sv */
// Package for the Type-C source attach output decoder.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
package typec_attach_pkg;

  // Register offsets
  localparam logic [7:0] CONN_STATUS_OFS  = 8'h0e;
  localparam logic [7:0] OP_STATE_OFS     = 8'h11;

  // Settled connection status codes
  localparam logic [7:0] CONN_NONE        = 8'h00;
  localparam logic [7:0] CONN_SINK        = 8'h2d;
  localparam logic [7:0] CONN_SINK_CABLE  = 8'h2f;
  localparam logic [7:0] CONN_DEBUG       = 8'h6d;
  localparam logic [7:0] CONN_AUDIO       = 8'h81;

  // Operation state codes (values of the state register)
  localparam logic [7:0] OP_UNATTACHED    = 8'h00;
  localparam logic [7:0] OP_ATTACHED      = 8'h01;
  localparam logic [7:0] OP_UNORIENT_DBG  = 8'h02;
  localparam logic [7:0] OP_ORIENT_DBG    = 8'h03;
  localparam logic [7:0] OP_AUDIO         = 8'h04;

  // Termination seen on one CC line; LOW is anything below a cable load
  typedef enum logic [2:0] {
    TERM_OPEN,
    TERM_RA,
    TERM_RD,
    TERM_RP,
    TERM_LOW
  } cc_term_e;

  // Type-C source state
  typedef enum logic [2:0] {
    ST_UNATTACHED,
    ST_ATTACHED,
    ST_UNORIENT_DBG,
    ST_ORIENT_DBG,
    ST_AUDIO
  } typec_state_e;

endpackage

/* File: src/typec_source_attach_outputs.sv */
// Decodes CC terminations into the source state, pins and status registers.
// Assumes terminations and monitor flags arrive from pins or analog blocks
// outside the clock domain; all are double-synchronised here.
//
// Function
// - Power enable drives low only in an attached or debug state with no overvoltage on a present supply and bus voltage in range.
// - Power enable is released whenever any one enabling condition fails.
// - A sink on one line with the other line open gives the attached state, power on, code 2Dh, orientation low only for line two, no VCONN.
// - Sink plus cable gives the attached state, VCONN on the cable line, power on, code 2Fh, orientation from the sink line.
// - Two sinks or a sink with a lower termination give debug states with 6Dh and power; two cables give audio with 81h and no power.
// - Open lines, a lone cable or two source pull-ups stay unattached with 00h, no VCONN and released outputs.
`timescale 1ns/10ps
module typec_source_attach_outputs (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic [2:0] cc1_term_in,
  input  wire logic [2:0] cc2_term_in,
  input  wire logic       supply_present_in,
  input  wire logic       supply_overvoltage_in,
  input  wire logic       bus_voltage_sense_ok_in,
  input  wire logic [7:0] reg_addr_in,
  output logic      [7:0] reg_rdata_out,
  output logic            source_power_enable_out,
  output logic            source_power_enable_oe_out,
  output logic            orientation_out,
  output logic            orientation_oe_out,
  output logic            vconn_cc1_on_out,
  output logic            vconn_cc2_on_out,
  output logic      [7:0] connection_status_out,
  output logic      [7:0] typec_operation_state_out
);

  typedef typec_attach_pkg::cc_term_e     cc_term_t;
  typedef typec_attach_pkg::typec_state_e st_t;

  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  cc_term_t   cc1_t;
  cc_term_t   cc2_t;
  logic       ovp_ok;
  logic       powered_state;
  logic       power_ok;
  st_t        state_next;
  logic [7:0] conn_next;
  logic       orient_oe_next;
  logic       vc1_next;
  logic       vc2_next;
  st_t        state_reg;
  logic       orient_oe_reg;
  logic       pwr_oe_reg;
  logic       vc1_reg;
  logic       vc2_reg;
  logic [7:0] conn_reg;
  logic [7:0] op_reg;

  // Map a state to its register code
  function automatic logic [7:0] op_code(input st_t s);
    case (s)
      typec_attach_pkg::ST_ATTACHED:     op_code = typec_attach_pkg::OP_ATTACHED;
      typec_attach_pkg::ST_UNORIENT_DBG: op_code = typec_attach_pkg::OP_UNORIENT_DBG;
      typec_attach_pkg::ST_ORIENT_DBG:   op_code = typec_attach_pkg::OP_ORIENT_DBG;
      typec_attach_pkg::ST_AUDIO:        op_code = typec_attach_pkg::OP_AUDIO;
      default:                           op_code = typec_attach_pkg::OP_UNATTACHED;
    endcase
  endfunction

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end
    else
    begin
      sync1_reg <= {cc1_term_in, cc2_term_in, supply_present_in,
                    supply_overvoltage_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign cc1_t = cc_term_t'(sync2_reg[7:5]);
  assign cc2_t = cc_term_t'(sync2_reg[4:2]);
  // Overvoltage only counts while the supply is present
  assign ovp_ok = !(sync2_reg[1] && sync2_reg[0]);

  // Bus sense has its own pair so the flops stay separate per source
  logic sense1_reg;
  logic sense2_reg;
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      sense1_reg <= 1'b0;
      sense2_reg <= 1'b0;
    end
    else
    begin
      sense1_reg <= bus_voltage_sense_ok_in;
      sense2_reg <= sense1_reg;
    end
  end

  // Termination decode into next state, status code and switches
  always_comb
  begin
    state_next     = typec_attach_pkg::ST_UNATTACHED;
    conn_next      = typec_attach_pkg::CONN_NONE;
    orient_oe_next = 1'b0;
    vc1_next       = 1'b0;
    vc2_next       = 1'b0;
    if (cc1_t == typec_attach_pkg::TERM_RD &&
        cc2_t == typec_attach_pkg::TERM_RD)
    begin
      state_next = typec_attach_pkg::ST_UNORIENT_DBG;
      conn_next  = typec_attach_pkg::CONN_DEBUG;
    end
    else if (cc1_t == typec_attach_pkg::TERM_RD &&
             cc2_t == typec_attach_pkg::TERM_OPEN)
    begin
      state_next = typec_attach_pkg::ST_ATTACHED;
      conn_next  = typec_attach_pkg::CONN_SINK;
    end
    else if (cc2_t == typec_attach_pkg::TERM_RD &&
             cc1_t == typec_attach_pkg::TERM_OPEN)
    begin
      state_next     = typec_attach_pkg::ST_ATTACHED;
      conn_next      = typec_attach_pkg::CONN_SINK;
      orient_oe_next = 1'b1;
    end
    // sink with cable; VCONN goes to the cable line
    else if (cc1_t == typec_attach_pkg::TERM_RD &&
             cc2_t == typec_attach_pkg::TERM_RA)
    begin
      state_next = typec_attach_pkg::ST_ATTACHED;
      conn_next  = typec_attach_pkg::CONN_SINK_CABLE;
      vc2_next   = 1'b1;
    end
    else if (cc2_t == typec_attach_pkg::TERM_RD &&
             cc1_t == typec_attach_pkg::TERM_RA)
    begin
      state_next     = typec_attach_pkg::ST_ATTACHED;
      conn_next      = typec_attach_pkg::CONN_SINK_CABLE;
      orient_oe_next = 1'b1;
      vc1_next       = 1'b1;
    end
    // sink with a termination below Ra; plain Ra was taken above
    else if (cc1_t == typec_attach_pkg::TERM_RD &&
             cc2_t != typec_attach_pkg::TERM_RP)
    begin
      state_next = typec_attach_pkg::ST_ORIENT_DBG;
      conn_next  = typec_attach_pkg::CONN_DEBUG;
    end
    else if (cc2_t == typec_attach_pkg::TERM_RD &&
             cc1_t != typec_attach_pkg::TERM_RP)
    begin
      state_next     = typec_attach_pkg::ST_ORIENT_DBG;
      conn_next      = typec_attach_pkg::CONN_DEBUG;
      orient_oe_next = 1'b1;
    end
    else if (cc1_t == typec_attach_pkg::TERM_RA &&
             cc2_t == typec_attach_pkg::TERM_RA)
    begin
      state_next = typec_attach_pkg::ST_AUDIO;
      conn_next  = typec_attach_pkg::CONN_AUDIO;
    end
    // everything else stays unattached with defaults
  end

  assign powered_state = (state_next == typec_attach_pkg::ST_ATTACHED) ||
                         (state_next == typec_attach_pkg::ST_UNORIENT_DBG) ||
                         (state_next == typec_attach_pkg::ST_ORIENT_DBG);
  // any failing condition drops the enable
  assign power_ok = powered_state && ovp_ok && sense2_reg;

  // State and pins; registers load in the same edge as the pins
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      state_reg     <= typec_attach_pkg::ST_UNATTACHED;
      orient_oe_reg <= 1'b0;
      vc1_reg       <= 1'b0;
      vc2_reg       <= 1'b0;
      conn_reg      <= typec_attach_pkg::CONN_NONE;
      op_reg        <= typec_attach_pkg::OP_UNATTACHED;
    end
    else
    begin
      state_reg     <= state_next;
      orient_oe_reg <= orient_oe_next;
      vc1_reg       <= vc1_next;
      vc2_reg       <= vc2_next;
      conn_reg      <= conn_next;
      op_reg        <= op_code(state_next);
    end
  end

  // enable loads on the same edge as the state, so connection_status_out
  // never disagrees with the pin; a status read lags the pin by one cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      pwr_oe_reg <= 1'b0;
    else
      pwr_oe_reg <= power_ok;
  end

  // Pins: drive low when enabled, release otherwise
  assign source_power_enable_out    = 1'b0;
  assign source_power_enable_oe_out = pwr_oe_reg;
  assign orientation_out            = 1'b0;
  assign orientation_oe_out         = orient_oe_reg;
  assign vconn_cc1_on_out           = vc1_reg;
  assign vconn_cc2_on_out           = vc2_reg;
  assign connection_status_out      = conn_reg;
  assign typec_operation_state_out  = op_reg;

  // Register read port; unmapped addresses read zero
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_addr_in == typec_attach_pkg::CONN_STATUS_OFS)
      reg_rdata_out <= conn_reg;
    else if (reg_addr_in == typec_attach_pkg::OP_STATE_OFS)
      reg_rdata_out <= op_reg;
    else
      reg_rdata_out <= 8'h00;
  end

  // Assertions
  power_cause_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    source_power_enable_oe_out |->
      $past(ovp_ok) && $past(sense2_reg) &&
      (typec_operation_state_out == typec_attach_pkg::OP_ATTACHED ||
       typec_operation_state_out == typec_attach_pkg::OP_UNORIENT_DBG ||
       typec_operation_state_out == typec_attach_pkg::OP_ORIENT_DBG))
    else $error("power enable without all conditions");
  power_drop_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !power_ok |=> !source_power_enable_oe_out)
    else $error("power enable kept after a failure");
  sink_code_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (connection_status_out == typec_attach_pkg::CONN_SINK) |->
      !vconn_cc1_on_out && !vconn_cc2_on_out)
    else $error("vconn on for plain sink");
  cable_vconn_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (connection_status_out == typec_attach_pkg::CONN_SINK_CABLE) |->
      (vconn_cc1_on_out ^ vconn_cc2_on_out))
    else $error("vconn not on exactly one line");
  audio_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (connection_status_out == typec_attach_pkg::CONN_AUDIO) |->
      !source_power_enable_oe_out)
    else $error("power on for audio accessory");
  idle_quiet_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (connection_status_out == typec_attach_pkg::CONN_NONE) |->
      !orientation_oe_out && !vconn_cc1_on_out && !vconn_cc2_on_out &&
      !source_power_enable_oe_out)
    else $error("outputs active while unattached");
  regs_match_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (typec_operation_state_out == typec_attach_pkg::OP_UNATTACHED) ==
      (connection_status_out == typec_attach_pkg::CONN_NONE))
    else $error("state register out of step");
  pin_match_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    source_power_enable_oe_out |->
      (connection_status_out == typec_attach_pkg::CONN_SINK ||
       connection_status_out == typec_attach_pkg::CONN_SINK_CABLE ||
       connection_status_out == typec_attach_pkg::CONN_DEBUG))
    else $error("power pin and status register disagree");
  read_back_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (reg_addr_in == typec_attach_pkg::CONN_STATUS_OFS) |=>
      reg_rdata_out == $past(conn_reg))
    else $error("status read mismatch");

  sink_cov: cover property (@(posedge clk_sys_in)
    connection_status_out == typec_attach_pkg::CONN_SINK_CABLE);
  dbg_cov: cover property (@(posedge clk_sys_in)
    connection_status_out == typec_attach_pkg::CONN_DEBUG &&
    source_power_enable_oe_out);
  audio_cov: cover property (@(posedge clk_sys_in)
    connection_status_out == typec_attach_pkg::CONN_AUDIO);
  orient_cov: cover property (@(posedge clk_sys_in)
    typec_operation_state_out == typec_attach_pkg::OP_ORIENT_DBG);

endmodule

/* File: sim/typec_far_end_model.sv */
// Model of what plugs into the receptacle: sink, cable or accessory.
// Assumes the bench asks for terminations just after a clock edge.
`timescale 1ns/10ps
module typec_far_end_model (
  input  wire logic       clk_in,
  input  wire logic [2:0] want_cc1_in,
  input  wire logic [2:0] want_cc2_in,
  output logic      [2:0] cc1_term_out = 3'h0,
  output logic      [2:0] cc2_term_out = 3'h0
);
  // Terminations land one edge late, so the sync path sees a clean step
  always_ff @(posedge clk_in)
  begin
    cc1_term_out <= want_cc1_in;
    cc2_term_out <= want_cc2_in;
  end
endmodule

/* File: sim/tb_typec_source_attach_outputs.sv */
// Self-checking bench for the Type-C source attach output decoder.
// Assumes the far-end model and the package are compiled first.
`timescale 1ns/10ps
module tb_typec_source_attach_outputs;
  logic       clk_sys_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic [2:0] want1 = 3'h0;
  logic [2:0] want2 = 3'h0;
  logic [2:0] cc1;
  logic [2:0] cc2;
  logic       sp = 1'b1;
  logic       ov = 1'b0;
  logic       ok = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] rdata;
  logic       pe;
  logic       pe_oe;
  logic       orient;
  logic       or_oe;
  logic       v1;
  logic       v2;
  logic [7:0] cs;
  logic [7:0] ops;
  int         mismatches = 0;
  int         n_compared = 0;

  // Clock at 250 MHz
  always #2 clk_sys_in = ~clk_sys_in;

  typec_far_end_model typec_far_end_model_inst (
    .clk_in       (clk_sys_in),
    .want_cc1_in  (want1),
    .want_cc2_in  (want2),
    .cc1_term_out (cc1),
    .cc2_term_out (cc2)
  );

  typec_source_attach_outputs typec_source_attach_outputs_inst (
    .clk_sys_in                 (clk_sys_in),
    .sys_rst_in                 (sys_rst_in),
    .cc1_term_in                (cc1),
    .cc2_term_in                (cc2),
    .supply_present_in          (sp),
    .supply_overvoltage_in      (ov),
    .bus_voltage_sense_ok_in    (ok),
    .reg_addr_in                (addr),
    .reg_rdata_out              (rdata),
    .source_power_enable_out    (pe),
    .source_power_enable_oe_out (pe_oe),
    .orientation_out            (orient),
    .orientation_oe_out         (or_oe),
    .vconn_cc1_on_out           (v1),
    .vconn_cc2_on_out           (v2),
    .connection_status_out      (cs),
    .typec_operation_state_out  (ops)
  );

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address is set after one edge, data stands after the next
  task automatic read_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    #1 addr = a;
    @(posedge clk_sys_in);
    #1 check("rdata", rdata, exp);
  endtask

  // Pins packed as orientation, vconn cc1, vconn cc2, power
  task automatic attach(input logic [2:0] c1, input logic [2:0] c2,
                        input logic [7:0] st, input logic [7:0] op,
                        input logic [3:0] pins);
    @(posedge clk_sys_in);
    #1 want1 = c1;
    want2 = c2;
    repeat (8) @(posedge clk_sys_in);
    #1 check("status", cs, st);
    check("state", ops, op);
    check("pins", {4'h0, or_oe, v1, v2, pe_oe}, {4'h0, pins});
    check("levels", {6'h0, pe, orient}, 8'h00);
    read_reg(typec_attach_pkg::CONN_STATUS_OFS, st);
    read_reg(typec_attach_pkg::OP_STATE_OFS, op);
  endtask

  task automatic test_table;
    attach(3'h0, 3'h0, 8'h00, 8'h00, 4'h0);
    attach(3'h2, 3'h0, 8'h2d, 8'h01, 4'h1);
    attach(3'h0, 3'h2, 8'h2d, 8'h01, 4'h9);
    attach(3'h0, 3'h1, 8'h00, 8'h00, 4'h0);
    attach(3'h2, 3'h1, 8'h2f, 8'h01, 4'h3);
    attach(3'h1, 3'h0, 8'h00, 8'h00, 4'h0);
    attach(3'h1, 3'h2, 8'h2f, 8'h01, 4'hd);
    attach(3'h3, 3'h3, 8'h00, 8'h00, 4'h0);
    attach(3'h2, 3'h2, 8'h6d, 8'h02, 4'h1);
    attach(3'h2, 3'h4, 8'h6d, 8'h03, 4'h1);
    attach(3'h4, 3'h2, 8'h6d, 8'h03, 4'h9);
    attach(3'h1, 3'h1, 8'h81, 8'h04, 4'h0);
    $display("test_table done");
  endtask

  task automatic mon(input logic p, input logic o, input logic k,
                     input logic exp);
    @(posedge clk_sys_in);
    #1 sp = p;
    ov = o;
    ok = k;
    repeat (5) @(posedge clk_sys_in);
    #1 check("power", {7'h0, pe_oe}, {7'h0, exp});
  endtask

  task automatic test_monitors;
    attach(3'h2, 3'h0, 8'h2d, 8'h01, 4'h1);
    mon(1'b1, 1'b0, 1'b0, 1'b0);
    mon(1'b1, 1'b0, 1'b1, 1'b1);
    mon(1'b1, 1'b1, 1'b1, 1'b0);
    mon(1'b0, 1'b1, 1'b1, 1'b1);
    mon(1'b1, 1'b0, 1'b1, 1'b1);
    $display("test_monitors done");
  endtask

  // Mid-run reset while attached, then an unmapped read
  task automatic test_reset_regs;
    @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b1;
    @(posedge clk_sys_in);
    #1 check("rst status", cs | ops, 8'h00);
    check("rst pins", {4'h0, or_oe, v1, v2, pe_oe}, 8'h00);
    sys_rst_in = 1'b0;
    read_reg(8'h05, 8'h00);
    $display("test_reset_regs done");
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after a two-cycle reset
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    test_table();
    test_monitors();
    test_reset_regs();
    summarize();
  end

  // Watchdog well past the expected run of about 200 cycles
  initial
  begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule
